// ===== src/fphm_pkg.sv
// Constants, types and carriers for the halve-long and multiply datapath.
// Assumes one clock, a synchronous register store that answers while the registered read request stands.
// Operation
// - Long halve shifts the whole 56-bit fraction right one bit, characteristic unchanged.
// - Long halve checks the register designations before touching the fraction.
// - High fraction goes to the work pair; low fraction is read from the store.
// - A zero halved fraction writes a true zero to the pair and ends.
// - Leading zero digits shift left four bits, characteristic minus one each.
// - Halve stores the low fraction to the odd register, then the even one.
// - The sign bit of the even-register store comes from the saved sign latch.
// - After the halve store, underflow is tested and the mask decides the rest.
// - Second operand is multiplicand, first is multiplier, result goes to first.
// - Short and long multiply both store a 64-bit product to the pair.
// - Product characteristic is the sum of both characteristics minus 64.
// - Each operand is prenormalized by hex left shifts, characteristic decremented.
// - Prenormalization below zero raises nothing; true values are used.
// - Product needs at most one post-normalization hex shift.
// - Long product bits beyond the retained width drop before post-shifting.
// - Short product keeps 14 digits; its two lowest digits are zero.
// - Product sign is plus for like signs, minus for unlike.
// - Final characteristic above 127 ends the operation with overflow interruption.
// - An intermediate characteristic above 127 is fine if normalization recovers it.
// - Final characteristic below zero zeroes the result; underflow only when masked in.
// - An all-zero product fraction gives a true zero, no underflow, no interruption.
// - Multiplication never raises a significance interruption.
// - Two multiplier bits per cycle from the low end, four-bit count from hex F.
// - A pending times-three carry after the last bits costs one extra cycle.
package fphm_pkg;

  localparam int FRAC_W = 56;
  localparam int CHR_W = 10;
  localparam logic [CHR_W-1:0] CHR_BIAS = 10'h040;
  localparam logic [CHR_W-1:0] CHR_MAX = 10'h07F;
  localparam logic [3:0] CNT_INIT = 4'hF;
  localparam int ACC_W = 116;
  localparam int ACC_ADD_LSB = 56;
  localparam int PROD_LSB = 48;
  localparam int SHORT_ZERO_BITS = 8;
  localparam logic [3:0] FREG_MAX = 4'h6;
  // Word layout of a float_reg high word
  localparam int SIGN_BIT = 31;
  localparam int CHR_MSB = 30;
  localparam int CHR_LSB = 24;
  localparam int HI_FRAC_W = 24;

  typedef enum logic [1:0] {
    FPHM_OP_HALVE_LONG,
    FPHM_OP_MUL_SHORT,
    FPHM_OP_MUL_LONG,
    FPHM_OP_NONE
  } fphm_op_e;

  typedef struct packed {
    fphm_op_e op;
    logic [3:0] first_operand_field;
    logic [3:0] second_operand_field;
    logic unf_mask;
  } fphm_cmd_s;

  typedef struct packed {
    logic en;
    logic [3:0] addr;
  } fphm_ls_rd_s;

  typedef struct packed {
    logic en;
    logic [3:0] addr;
    logic [31:0] data;
  } fphm_ls_wr_s;

  typedef struct packed {
    logic spec;
    logic ovf;
    logic unf;
  } fphm_exc_s;

endpackage

// ===== src/fphm_mul_step.sv
// One two-bit step of the recoded fraction multiply.
// Combinational; the caller registers the accumulator and the carry trigger.
`timescale 1ns/1ps
module fphm_mul_step
  import fphm_pkg::*;
(
  input wire logic [ACC_W-1:0] acc,
  input wire logic [FRAC_W-1:0] mcand,
  input wire logic [1:0] mbits,
  input wire logic tx,
  input wire logic term,
  output logic [ACC_W-1:0] next_acc,
  output logic next_tx
);

  logic [ACC_W-1:0] mult;
  logic [ACC_W-1:0] sum;
  logic [ACC_W-1:0] one_x;

  always_comb begin
    one_x = ACC_W'(mcand) << ACC_ADD_LSB;
    mult = '0;
    next_tx = 1'b0;
    if (term) begin
      mult = one_x;
    end else begin
      // Times three is times four minus one; tx carries the four
      unique case ({tx, mbits})
        3'b000: mult = '0;
        3'b001: mult = one_x;
        3'b010: mult = one_x << 1;
        3'b011: begin
          mult = -one_x;
          next_tx = 1'b1;
        end
        3'b100: mult = one_x;
        3'b101: mult = one_x << 1;
        3'b110: begin
          mult = -one_x;
          next_tx = 1'b1;
        end
        3'b111: begin
          mult = '0;
          next_tx = 1'b1;
        end
      endcase
    end
    sum = acc + mult;
    // Shift right two every step; the terminating add does not shift
    next_acc = term ? sum : ACC_W'($signed(sum) >>> 2);
  end

endmodule // fphm_mul_step

// ===== src/fphm_unit.sv
// Halve-long and floating multiply datapath under sequencer control.
// Assumes the local register store answers while the registered read request stands.
`timescale 1ns/1ps
module fphm_unit
  import fphm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire fphm_cmd_s cmd,
  output logic busy,
  output fphm_ls_rd_s ls_rd,
  input wire logic [31:0] ls_rd_data,
  output fphm_ls_wr_s ls_wr,
  output logic done,
  output fphm_exc_s exc
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_RD, S_RDW, S_HV_LOAD, S_HV_NORM, S_MUL_SETUP, S_PRE,
    S_MUL, S_TERM, S_POST, S_WR_LO, S_WR_HI, S_CHK, S_FIN
  } fphm_state_e;

  fphm_state_e state, next_state;
  fphm_cmd_s cur, next_cur;
  logic [1:0] rix, next_rix;
  logic [31:0] w [4];
  logic [31:0] next_w [4];
  logic sign, next_sign;
  logic [CHR_W-1:0] chr, next_chr;
  logic [FRAC_W-1:0] fa, next_fa;
  logic [FRAC_W-1:0] fb, next_fb;
  logic [ACC_W-1:0] acc, next_acc;
  logic tx, next_tx;
  logic [3:0] cnt, next_cnt;
  logic pass, next_pass;
  fphm_ls_rd_s next_ls_rd;
  fphm_ls_wr_s next_ls_wr;
  logic next_done;
  fphm_exc_s next_exc;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic is_halve;
  logic is_long;
  logic [1:0] last_rix;
  logic [3:0] rd_addr;
  logic [31:0] mword;
  logic [1:0] mbits;
  logic step_term;
  logic [ACC_W-1:0] step_acc;
  logic step_tx;
  logic spec_bad;

  assign is_halve = (cur.op == FPHM_OP_HALVE_LONG);
  assign is_long = (cur.op != FPHM_OP_MUL_SHORT);
  assign last_rix = (cur.op == FPHM_OP_MUL_LONG) ? 2'h3 : 2'h1;
  // Designations must name an even register pair within range
  assign spec_bad = cmd.first_operand_field[0] || cmd.second_operand_field[0]
    || (cmd.first_operand_field > FREG_MAX) || (cmd.second_operand_field > FREG_MAX)
    || (cmd.op == FPHM_OP_NONE);

  always_comb begin
    // Halve reads R2 then R2+1; multiply reads R1, R2, then for long multiply the odd halves
    rd_addr = cur.second_operand_field;
    unique case ({is_halve, rix})
      3'b100: rd_addr = cur.second_operand_field;
      3'b101: rd_addr = cur.second_operand_field | 4'h1;
      3'b000: rd_addr = cur.first_operand_field;
      3'b001: rd_addr = cur.second_operand_field;
      3'b010: rd_addr = cur.first_operand_field | 4'h1;
      3'b011: rd_addr = cur.second_operand_field | 4'h1;
      default: rd_addr = cur.second_operand_field;
    endcase
  end

  always_comb begin
    // Multiplier words: short uses the high part once, long low then high
    if (pass) begin
      mword = {8'h00, fa[FRAC_W-1:32]};
    end else if (is_long) begin
      mword = fa[31:0];
    end else begin
      mword = {8'h00, fa[FRAC_W-1:32]};
    end
    // Count F picks the lowest pair, each step moves two bits left
    mbits = mword[{~cnt, 1'b0} +: 2];
  end

  assign step_term = (state == S_TERM);

  fphm_mul_step u_step (
    .acc(acc),
    .mcand(fb),
    .mbits(mbits),
    .tx(tx),
    .term(step_term),
    .next_acc(step_acc),
    .next_tx(step_tx)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [FRAC_W-1:0] p;
    logic [CHR_W-1:0] pc;
    logic [CHR_W-1:0] dec;
    p = '0;
    pc = '0;
    dec = '0;
    next_state = state;
    next_cur = cur;
    next_rix = rix;
    next_w = w;
    next_sign = sign;
    next_chr = chr;
    next_fa = fa;
    next_fb = fb;
    next_acc = acc;
    next_tx = tx;
    next_cnt = cnt;
    next_pass = pass;
    next_ls_rd = '0;
    next_ls_wr = '0;
    next_done = 1'b0;
    next_exc = exc;
    unique case (state)
      S_IDLE: begin
        if (start) begin
          next_cur = cmd;
          next_exc = '0;
          next_rix = '0;
          if (spec_bad) begin
            next_exc.spec = 1'b1;
            next_state = S_FIN;
          end else begin
            next_state = S_RD;
          end
        end
      end
      S_RD: begin
        next_ls_rd.en = 1'b1;
        next_ls_rd.addr = rd_addr;
        next_state = S_RDW;
      end
      S_RDW: begin
        if (ls_rd.en) begin
          next_w[rix] = ls_rd_data;
        end
        if (!ls_rd.en) begin
          next_state = S_RDW;
        end else if (rix == last_rix) begin
          next_state = is_halve ? S_HV_LOAD : S_MUL_SETUP;
        end else begin
          next_rix = rix + 2'h1;
          next_state = S_RD;
        end
      end
      S_HV_LOAD: begin
        next_sign = w[0][SIGN_BIT];
        next_chr = CHR_W'(w[0][CHR_MSB:CHR_LSB]);
        next_fa = {w[0][HI_FRAC_W-1:0], w[1]} >> 1;
        next_state = S_HV_NORM;
      end
      S_HV_NORM: begin
        if (fa == '0) begin
          next_sign = 1'b0;
          next_chr = '0;
          next_state = S_WR_LO;
        end else if (fa[FRAC_W-1 -: 4] == 4'h0) begin
          next_fa = fa << 4;
          next_chr = chr - 10'h001;
        end else begin
          next_state = S_WR_LO;
        end
      end
      S_MUL_SETUP: begin
        // Word 0 is the multiplier, word 1 the multiplicand
        next_sign = w[0][SIGN_BIT] ^ w[1][SIGN_BIT];
        next_chr = CHR_W'(w[0][CHR_MSB:CHR_LSB]) + CHR_W'(w[1][CHR_MSB:CHR_LSB])
          - CHR_BIAS;
        next_fa = {w[0][HI_FRAC_W-1:0], is_long ? w[2] : 32'h0000_0000};
        next_fb = {w[1][HI_FRAC_W-1:0], is_long ? w[3] : 32'h0000_0000};
        next_state = S_PRE;
      end
      S_PRE: begin
        if (fa == '0 || fb == '0) begin
          next_sign = 1'b0;
          next_chr = '0;
          next_fa = '0;
          next_state = S_WR_LO;
        end else begin
          // No underflow check here; chr may go negative
          dec = '0;
          if (fa[FRAC_W-1 -: 4] == 4'h0) begin
            next_fa = fa << 4;
            dec = dec + 10'h001;
          end
          if (fb[FRAC_W-1 -: 4] == 4'h0) begin
            next_fb = fb << 4;
            dec = dec + 10'h001;
          end
          next_chr = chr - dec;
          if (dec == '0) begin
            next_acc = '0;
            next_tx = 1'b0;
            next_cnt = CNT_INIT;
            next_pass = 1'b0;
            next_state = S_MUL;
          end
        end
      end
      S_MUL: begin
        next_acc = step_acc;
        next_tx = step_tx;
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h0) begin
          if (is_long && !pass) begin
            next_pass = 1'b1;
            next_cnt = CNT_INIT;
          end else begin
            next_state = step_tx ? S_TERM : S_POST;
          end
        end
      end
      S_TERM: begin
        next_acc = step_acc;
        next_tx = 1'b0;
        next_state = S_POST;
      end
      S_POST: begin
        // Retained width taken before any shift
        p = acc[PROD_LSB +: FRAC_W];
        if (!is_long) begin
          p[SHORT_ZERO_BITS-1:0] = '0;
        end
        pc = chr;
        if (p[FRAC_W-1 -: 4] == 4'h0) begin
          p = p << 4;
          pc = chr - 10'h001;
        end
        next_fa = p;
        next_chr = pc;
        // No significance exception exists for multiply
        if (p == '0) begin
          next_sign = 1'b0;
          next_chr = '0;
          next_state = S_WR_LO;
        end else if (!pc[CHR_W-1] && (pc > CHR_MAX)) begin
          next_exc.ovf = 1'b1;
          next_state = S_FIN;
        end else if (pc[CHR_W-1]) begin
          next_sign = 1'b0;
          next_chr = '0;
          next_fa = '0;
          next_exc.unf = cur.unf_mask;
          next_state = S_WR_LO;
        end else begin
          next_state = S_WR_LO;
        end
      end
      S_WR_LO: begin
        next_ls_wr.en = 1'b1;
        next_ls_wr.addr = cur.first_operand_field | 4'h1;
        next_ls_wr.data = fa[31:0];
        next_state = S_WR_HI;
      end
      S_WR_HI: begin
        next_ls_wr.en = 1'b1;
        next_ls_wr.addr = cur.first_operand_field;
        next_ls_wr.data = {sign, chr[6:0], fa[FRAC_W-1:32]};
        next_state = S_CHK;
      end
      S_CHK: begin
        next_state = S_FIN;
        if (is_halve && chr[CHR_W-1]) begin
          if (cur.unf_mask) begin
            next_exc.unf = 1'b1;
          end else begin
            next_sign = 1'b0;
            next_chr = '0;
            next_fa = '0;
            next_state = S_WR_LO;
          end
        end
      end
      S_FIN: begin
        next_done = 1'b1;
        next_state = S_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= S_IDLE;
      cur <= '0;
      rix <= '0;
      w <= '{default: '0};
      sign <= 1'b0;
      chr <= '0;
      fa <= '0;
      fb <= '0;
      acc <= '0;
      tx <= 1'b0;
      cnt <= '0;
      pass <= 1'b0;
      ls_rd <= '0;
      ls_wr <= '0;
      done <= 1'b0;
      exc <= '0;
    end else begin
      state <= next_state;
      cur <= next_cur;
      rix <= next_rix;
      w <= next_w;
      sign <= next_sign;
      chr <= next_chr;
      fa <= next_fa;
      fb <= next_fb;
      acc <= next_acc;
      tx <= next_tx;
      cnt <= next_cnt;
      pass <= next_pass;
      ls_rd <= next_ls_rd;
      ls_wr <= next_ls_wr;
      done <= next_done;
      exc <= next_exc;
    end
  end

  assign busy = (state != S_IDLE);

endmodule // fphm_unit

// ===== sim/fphm_store_model.sv
// Local register store model: sixteen 32-bit words, answers while ls_rd.en stands.
// Assumes fphm_unit pulses ls_rd/ls_wr; the bench preloads mem directly.
`timescale 1ns/1ps
module fphm_store_model
  import fphm_pkg::*;
(
  input wire logic clk,
  input wire fphm_ls_rd_s ls_rd,
  input wire fphm_ls_wr_s ls_wr,
  output logic [31:0] ls_rd_data
);
  logic [31:0] mem [0:15];
  logic [31:0] last;
  initial begin
    last = 32'h0;
  end
  always @(posedge clk) begin
    if (ls_rd.en) begin
      last <= mem[ls_rd.addr];
    end
    if (ls_wr.en) begin
      mem[ls_wr.addr] <= ls_wr.data;
    end
  end
  // Word stands while the request stands; afterwards the bus shows its inverse
  assign ls_rd_data = ls_rd.en ? mem[ls_rd.addr] : ~last;
endmodule // fphm_store_model

// ===== sim/fphm_unit_asserts.sv
// Port assertions for the halve and multiply datapath.
// Assumes binding onto fphm_unit; one clock, synchronous reset.
`timescale 1ns/1ps
module fphm_unit_asserts
  import fphm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire fphm_cmd_s cmd,
  input wire logic busy,
  input wire fphm_ls_rd_s ls_rd,
  input wire logic [31:0] ls_rd_data,
  input wire fphm_ls_wr_s ls_wr,
  input wire logic done,
  input wire fphm_exc_s exc
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic take;
  logic bad;
  assign take = start && !busy;
  assign bad = cmd.op == FPHM_OP_NONE || cmd.first_operand_field[0]
    || cmd.second_operand_field[0] || cmd.first_operand_field > FREG_MAX
    || cmd.second_operand_field > FREG_MAX;
  spec_refuse_a: assert property (take && bad |=> !ls_rd.en && !ls_wr.en
    ##1 done && exc.spec && !ls_rd.en && !ls_wr.en) else $error("bad command not refused");
  halve_read_a: assert property (take && !bad && cmd.op == FPHM_OP_HALVE_LONG
    |-> ##2 ls_rd.en && ls_rd.addr == $past(cmd.second_operand_field, 2)) else $error("halve read");
  pair_order_a: assert property (ls_wr.en && !ls_wr.addr[0]
    |-> $past(ls_wr.en) && $past(ls_wr.addr) == ls_wr.addr + 4'h1) else $error("pair order");
  true_zero_a: assert property (ls_wr.en && !ls_wr.addr[0] && ls_wr.data[23:0] == 24'h0
    |-> ls_wr.data[31:24] == 8'h00) else $error("zero fraction with sign or exponent");
  done_pulse_a: assert property (done |=> !done) else $error("done longer than one cycle");
  take_clear_a: assert property (take && !bad |=> busy && exc == '0) else $error("start not taken");
  exc_hold_a: assert property (!busy && !start |=> $stable(exc)) else $error("flags moved");
  ovf_nowrite_a: assert property (done && exc.ovf
    |-> !$past(ls_wr.en) && !$past(ls_wr.en, 2)) else $error("write before overflow");
  idle_quiet_a: assert property (ls_wr.en || ls_rd.en |-> busy) else $error("access idle");
  rd_pulse_a: assert property (ls_rd.en |=> !ls_rd.en) else $error("read held");
endmodule // fphm_unit_asserts
bind fphm_unit fphm_unit_asserts u_fphm_unit_asserts (.clk(clk), .rst(rst), .start(start),
  .cmd(cmd), .busy(busy), .ls_rd(ls_rd), .ls_rd_data(ls_rd_data), .ls_wr(ls_wr),
  .done(done), .exc(exc));

// ===== sim/test_fp_halve_long_and_multiply.sv
// Self-checking bench for fphm_unit with a register store model.
// Assumes a 200 MHz clock and synchronous active-high reset.
`timescale 1ns/1ps
module test_fp_halve_long_and_multiply;
  import fphm_pkg::*;
  logic clk;
  logic rst;
  logic start;
  logic busy;
  logic done;
  fphm_cmd_s cmd;
  fphm_ls_rd_s ls_rd;
  fphm_ls_wr_s ls_wr;
  fphm_exc_s exc;
  logic [31:0] ls_rd_data;
  logic [31:0] sh [0:15];
  logic [35:0] q_wr [$];
  logic [2:0] q_exc [$];
  int n_fail = 0;
  int n_tests = 0;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  fphm_unit u_fphm_unit (.clk(clk), .rst(rst), .start(start), .cmd(cmd), .busy(busy),
    .ls_rd(ls_rd), .ls_rd_data(ls_rd_data), .ls_wr(ls_wr), .done(done), .exc(exc));
  fphm_store_model u_fphm_store_model (.clk(clk), .ls_rd(ls_rd), .ls_wr(ls_wr),
    .ls_rd_data(ls_rd_data));
  task automatic final_report();
    if (q_wr.size() != 0 || q_exc.size() != 0) begin
      n_fail++;
      $display("[FAIL] pending results expected 0 seen %0d", q_wr.size() + q_exc.size());
    end
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk_wr(input logic [35:0] seen);
    logic [35:0] e;
    e = (q_wr.size() > 0) ? q_wr.pop_front() : 'x;
    n_tests++;
    if (e !== seen) begin
      n_fail++;
      $display("[FAIL] store write expected %h seen %h", e, seen);
    end
  endtask
  task automatic chk_exc(input logic [2:0] seen);
    logic [2:0] e;
    e = (q_exc.size() > 0) ? q_exc.pop_front() : 'x;
    n_tests++;
    if (e !== seen) begin
      n_fail++;
      $display("[FAIL] exception flags expected %b seen %b", e, seen);
    end
  endtask
  always @(posedge clk) begin
    if (ls_wr.en === 1'b1) begin
      chk_wr({ls_wr.addr, ls_wr.data});
    end
    if (done === 1'b1) begin
      chk_exc(exc);
    end
  end
  task automatic set_reg(input logic [3:0] r, input logic [31:0] h, input logic [31:0] l);
    sh[r] = h;
    sh[r + 4'h1] = l;
    u_fphm_store_model.mem[r] = h;
    u_fphm_store_model.mem[r + 4'h1] = l;
  endtask
  task automatic put(input logic [3:0] r, input logic s, input int c, input logic [55:0] f);
    q_wr.push_back({r + 4'h1, f[31:0]});
    q_wr.push_back({r, s, c[6:0], f[55:32]});
    sh[r + 4'h1] = f[31:0];
    sh[r] = {s, c[6:0], f[55:32]};
  endtask
  task automatic norm(inout logic [55:0] f, inout int c);
    while (f != '0 && f[55:52] == 4'h0) begin
      f = f << 4;
      c = c - 1;
    end
  endtask
  // ----------------------------------------
  // Expected results
  // ----------------------------------------
  task automatic expect_op(input fphm_op_e op, input logic [3:0] r1, input logic [3:0] r2,
      input logic m);
    logic [55:0] fa;
    logic [55:0] fb;
    logic [111:0] p;
    int ca;
    int cb;
    logic s;
    if (op == FPHM_OP_NONE || r1[0] || r2[0] || r1 > FREG_MAX || r2 > FREG_MAX) begin
      q_exc.push_back(3'b100);
      return;
    end
    fb = {sh[r2][23:0], sh[r2 + 4'h1]};
    cb = sh[r2][30:24];
    s = sh[r2][31];
    if (op == FPHM_OP_HALVE_LONG) begin
      fb = fb >> 1;
      norm(fb, cb);
      if (fb == '0 || (cb < 0 && !m)) begin
        if (fb != '0) begin
          put(r1, s, cb, fb);
        end
        put(r1, 1'b0, 0, '0);
      end else begin
        put(r1, s, cb, fb);
      end
      q_exc.push_back({2'b00, fb != '0 && cb < 0 && m});
      return;
    end
    fa = {sh[r1][23:0], sh[r1 + 4'h1]};
    if (op == FPHM_OP_MUL_SHORT) begin
      fa[31:0] = '0;
      fb[31:0] = '0;
    end
    ca = sh[r1][30:24];
    s = sh[r1][31] ^ sh[r2][31];
    norm(fa, ca);
    norm(fb, cb);
    p = fa * fb;
    fa = p[111:56];
    ca = ca + cb - 64;
    if (fa[55:52] == 4'h0) begin
      fa = fa << 4;
      ca = ca - 1;
    end
    if (fa == '0 || (ca < 0 && ca <= 127)) begin
      put(r1, 1'b0, 0, '0);
      q_exc.push_back({2'b00, fa != '0 && m});
    end else if (ca > 127) begin
      q_exc.push_back(3'b010);
    end else begin
      put(r1, s, ca, fa);
      q_exc.push_back(3'b000);
    end
  endtask
  task automatic run_op(input fphm_op_e op, input logic [3:0] r1, input logic [3:0] r2,
      input logic m, input int hold);
    int n;
    expect_op(op, r1, r2, m);
    @(posedge clk);
    start <= 1'b1;
    cmd <= '{op, r1, r2, m};
    repeat (hold) @(posedge clk);
    start <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) begin
      n_fail++;
      $display("[FAIL] done expected 1 seen %b", done);
      final_report();
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    int i;
    logic [3:0] a;
    logic [3:0] b;
    rst = 1'b1;
    start = 1'b0;
    cmd = '0;
    void'($urandom(95414));
    for (i = 0; i < 8; i += 2) begin
      set_reg(4'(i), 32'h0, 32'h0);
    end
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    set_reg(4'h2, 32'hC1800000, 32'h00000001);
    run_op(FPHM_OP_HALVE_LONG, 4'h0, 4'h2, 1'b0, 2);
    set_reg(4'h4, 32'h41000001, 32'h0);
    run_op(FPHM_OP_HALVE_LONG, 4'h6, 4'h4, 1'b0, 1);
    set_reg(4'h6, 32'h85000000, 32'h00000001);
    run_op(FPHM_OP_HALVE_LONG, 4'h0, 4'h6, 1'b1, 1);
    set_reg(4'h2, 32'h00100000, 32'h0);
    run_op(FPHM_OP_HALVE_LONG, 4'h0, 4'h2, 1'b0, 1);
    run_op(FPHM_OP_HALVE_LONG, 4'h0, 4'h2, 1'b1, 1);
    run_op(FPHM_OP_NONE, 4'h0, 4'h2, 1'b0, 1);
    run_op(FPHM_OP_MUL_SHORT, 4'h1, 4'h2, 1'b0, 1);
    run_op(FPHM_OP_HALVE_LONG, 4'h0, 4'h8, 1'b0, 1);
    set_reg(4'h0, 32'h41000000, 32'h0);
    set_reg(4'h2, 32'h41123456, 32'h0);
    run_op(FPHM_OP_MUL_LONG, 4'h0, 4'h2, 1'b1, 1);
    set_reg(4'h0, 32'h7F800000, 32'h0);
    set_reg(4'h2, 32'hFF800000, 32'h0);
    run_op(FPHM_OP_MUL_LONG, 4'h0, 4'h2, 1'b0, 1);
    set_reg(4'h0, 32'h60100000, 32'h0);
    set_reg(4'h2, 32'h60100000, 32'h0);
    run_op(FPHM_OP_MUL_SHORT, 4'h0, 4'h2, 1'b0, 1);
    for (i = 0; i < 2; i++) begin
      set_reg(4'h4, 32'h10200000, 32'h0);
      set_reg(4'h6, 32'h90300000, 32'h0);
      run_op(FPHM_OP_MUL_LONG, 4'h4, 4'h6, 1'(i), 1);
    end
    set_reg(4'h0, 32'h00000012, 32'h0);
    set_reg(4'h2, 32'h50ABCDEF, 32'h0);
    run_op(FPHM_OP_MUL_SHORT, 4'h0, 4'h2, 1'b0, 1);
    for (i = 0; i < 16; i++) begin
      a = 4'(2 * $urandom_range(3, 0));
      b = 4'(2 * $urandom_range(3, 0));
      set_reg(a, $urandom, $urandom);
      set_reg(b, $urandom, $urandom);
      run_op(fphm_op_e'($urandom_range(2, 0)), a, b, 1'($urandom), 1);
    end
    repeat (2) @(posedge clk);
    final_report();
  end
endmodule // test_fp_halve_long_and_multiply
